// ### design/iscr_config_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Core logic advances on input clock divided by four.
// RL2: Sequencer control is 11 bits, resets 0x029.
// RL3: Controller writes only while frame valid low.
// RL4: Master and granularity change only in reset.
// RL5: Master mode self-timed; slave follows integration pins.
// RL6: Subsampling reads alternate rows; off by default.
// RL7: Granularity selects shutter clock division by range.
// RL8: Analog output amplifier enable, default off.
// RL9: Gain calibration every line or once per frame.
// RL10: Dual slope reset only when enabled; in slave mode DUAL_RESET follows INT_TIME_IN[1] whatever the enable.
// RL11: Triple slope reset only when enabled; in slave mode TRIPLE_RESET follows INT_TIME_IN[2] whatever the enable.
// RL12: Reverse bits select X and Y directions.
// RL13: Non-destructive readout enable, default off.
// RL14: Column start in 8-pixel groups, 0 to 79.
// RL15: Row start per line, 0 to 479.
// RL16: Kernels per line 1 to 160, default 160.
// RL17: Pixel reset lasts value minus one lines.
// RL18: Dual, triple, transfer positions; transfer default 0x1e1.
// RL19: Three reference DAC codes with given defaults.
// RL20: Input path register holds three 4-bit fields.
// RL21: Gain register fields, default 0xfb0.
// RL22: 33-bit calibration word over registers 13-15.
// RL23: Serial word: address 15:12, data 11:0.
// RL24: Ignore unused upper bits; defaults held in reset.
module iscr_config_regs
  import iscr_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        SER_CLK,
  input  wire logic        SER_ENABLE,
  input  wire logic        SER_DATA,
  input  wire logic        FRAME_VALID,
  input  wire logic [2:0]  INT_TIME_IN,
  input  wire logic        LINE_DONE,
  input  wire logic        FRAME_START,
  output logic             CORE_TICK,
  output iscr_seq_t        SEQ_CTRL,
  output logic [1:0]       SHUTTER_DIV,
  output logic [9:0]       START_PIXEL,
  output logic [8:0]       START_ROW,
  output logic [7:0]       KERNELS,
  output logic             ROW_SKIP,
  output logic             PIXEL_RESET,
  output logic             DUAL_RESET,
  output logic             TRIPLE_RESET,
  output logic             FRAME_TRANSFER,
  output logic [2:0]       INT_TIME_OUT,
  output logic             ANALOG_OUT_EN,
  output logic             CALIB_STROBE,
  output logic [7:0]       CAL_REF,
  output logic [7:0]       BLACK_REF,
  output logic [7:0]       OFFSET_REF,
  output iscr_paths_t      INPUT_PATHS,
  output iscr_gain_t       GAIN,
  output logic [32:0]      TRIM_WORD,
  output logic             WRITE_REFUSED
);

  // Serial pins are asynchronous: two flops each before use
  logic [1:0]  sclk_sync_ff;
  logic [1:0]  sen_sync_ff;
  logic [1:0]  sdat_sync_ff;
  logic [2:0]  int_sync_a_ff;
  logic [2:0]  int_sync_b_ff;
  logic        sclk_prev_ff;
  logic        sen_prev_ff;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [4:0]  bit_count_ff;
  logic [4:0]  nxt_bit_count;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sclk_sync_ff  <= 2'h0;
      sen_sync_ff   <= 2'h0;
      sdat_sync_ff  <= 2'h0;
      int_sync_a_ff <= 3'h0;
      int_sync_b_ff <= 3'h0;
    end
    else
    begin
      sclk_sync_ff  <= {sclk_sync_ff[0], SER_CLK};
      sen_sync_ff   <= {sen_sync_ff[0], SER_ENABLE};
      sdat_sync_ff  <= {sdat_sync_ff[0], SER_DATA};
      int_sync_a_ff <= INT_TIME_IN;
      int_sync_b_ff <= int_sync_a_ff;
    end
  end

  wire sclk_rise  = sclk_sync_ff[1] & ~sclk_prev_ff;
  wire sen_rise   = sen_sync_ff[1] & ~sen_prev_ff;
  // Loaded on the enable edge, and only once all 16 bits arrived
  wire word_full  = (bit_count_ff > WORD_BITS_LAST); // RL23
  wire load_word  = sen_rise & word_full; // RL23
  wire [3:0]  waddr = shift_ff[15:12]; // RL23
  wire [11:0] wdata = shift_ff[11:0]; // RL23
  // Writes during an active frame are dropped rather than corrupting readout
  wire frame_ok   = ~FRAME_VALID; // RL3
  wire accept     = load_word & frame_ok;

  assign nxt_shift     = sclk_rise ? {shift_ff[14:0], sdat_sync_ff[1]} : shift_ff;
  assign nxt_bit_count = sen_rise ? 5'h00 :
                         (sclk_rise && !word_full) ? bit_count_ff + 5'h01 : bit_count_ff;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sclk_prev_ff <= 1'b0;
      sen_prev_ff  <= 1'b0;
      shift_ff     <= 16'h0000;
      bit_count_ff <= 5'h00;
    end
    else
    begin
      sclk_prev_ff <= sclk_sync_ff[1];
      sen_prev_ff  <= sen_sync_ff[1];
      shift_ff     <= nxt_shift;
      bit_count_ff <= nxt_bit_count;
    end
  end

  // Register file
  logic [10:0] seq_ff;
  logic [7:0]  start_col_ff;
  logic [8:0]  start_row_ff;
  logic [7:0]  kernels_ff;
  logic [11:0] rst_len_ff;
  logic [11:0] dual_pos_ff;
  logic [11:0] triple_pos_ff;
  logic [11:0] ft_pos_ff;
  logic [7:0]  cal_ref_ff;
  logic [7:0]  black_ref_ff;
  logic [7:0]  offset_ref_ff;
  logic [11:0] paths_ff;
  logic [11:0] gain_ff;
  logic [11:0] trim_low_ff;
  logic [11:0] trim_mid_ff;
  logic [8:0]  trim_high_ff;
  logic        refused_ff;

  wire [15:0] hit = accept ? (16'h0001 << waddr) : 16'h0000;
  // Mode and granularity bits keep their value: sensor reset only changes them
  // Bit 1 (subsampling) stays writable; only bits 0, 2 and 3 are held
  wire [10:0] seq_keep_mask = 11'h00d; // RL4
  wire [10:0] nxt_seq = (seq_ff & seq_keep_mask) | (wdata[10:0] & ~seq_keep_mask); // RL2

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      seq_ff        <= RST_SEQ_CTRL; // RL2 RL24
      start_col_ff  <= RST_START_COL;
      start_row_ff  <= RST_START_ROW;
      kernels_ff    <= RST_KERNELS;
      rst_len_ff    <= RST_RST_LEN;
      dual_pos_ff   <= RST_DUAL_POS;
      triple_pos_ff <= RST_TRIPLE_POS;
      ft_pos_ff     <= RST_FT_POS; // RL18
      cal_ref_ff    <= RST_CAL_REF; // RL19
      black_ref_ff  <= RST_BLACK_REF;
      offset_ref_ff <= RST_OFFSET_REF;
      paths_ff      <= RST_INPUT_PATHS; // RL20
      gain_ff       <= RST_GAIN; // RL21
      trim_low_ff   <= RST_TRIM_LOW; // RL22
      trim_mid_ff   <= RST_TRIM_MID;
      trim_high_ff  <= RST_TRIM_HIGH;
      refused_ff    <= 1'b0;
    end
    else
    begin
      if (hit[ADDR_SEQ_CTRL])    seq_ff        <= nxt_seq;
      if (hit[ADDR_START_COL])   start_col_ff  <= wdata[7:0]; // RL24
      if (hit[ADDR_START_ROW])   start_row_ff  <= wdata[8:0];
      if (hit[ADDR_KERNELS])     kernels_ff    <= wdata[7:0];
      if (hit[ADDR_RST_LEN])     rst_len_ff    <= wdata;
      if (hit[ADDR_DUAL_POS])    dual_pos_ff   <= wdata;
      if (hit[ADDR_TRIPLE_POS])  triple_pos_ff <= wdata;
      if (hit[ADDR_FT_POS])      ft_pos_ff     <= wdata;
      if (hit[ADDR_CAL_REF])     cal_ref_ff    <= wdata[7:0];
      if (hit[ADDR_BLACK_REF])   black_ref_ff  <= wdata[7:0];
      if (hit[ADDR_OFFSET_REF])  offset_ref_ff <= wdata[7:0];
      if (hit[ADDR_INPUT_PATHS]) paths_ff      <= wdata;
      if (hit[ADDR_GAIN])        gain_ff       <= wdata;
      if (hit[ADDR_TRIM_LOW])    trim_low_ff   <= wdata;
      if (hit[ADDR_TRIM_MID])    trim_mid_ff   <= wdata;
      if (hit[ADDR_TRIM_HIGH])   trim_high_ff  <= wdata[8:0]; // RL24
      if (load_word)             refused_ff    <= FRAME_VALID; // RL3
    end
  end

  iscr_seq_t seq;
  assign seq = iscr_seq_t'(seq_ff);

  // Out-of-range window values are clamped to the legal span
  wire [7:0] col_clamped = (start_col_ff > START_COL_MAX) ? START_COL_MAX : start_col_ff; // RL14
  wire [8:0] row_clamped = (start_row_ff > START_ROW_MAX) ? START_ROW_MAX : start_row_ff; // RL15
  wire [7:0] ker_clamped = (kernels_ff == 8'h00) ? 8'h01 :
                           (kernels_ff > KERNELS_MAX) ? KERNELS_MAX : kernels_ff; // RL16
  wire [11:0] len_eff    = (rst_len_ff < RST_LEN_MIN) ? RST_LEN_MIN : rst_len_ff; // RL17

  // Core tick from the divider gates all sequencer timing except the slave-mode pin path
  logic core_tick;
  iscr_core_clock_div u_div (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .core_tick (core_tick)
  ); // RL1

  // Line counter for integration timing, counted on the core tick
  logic [11:0] line_ff;
  logic        row_phase_ff;
  wire line_step = core_tick & LINE_DONE;
  wire frame_step = core_tick & FRAME_START;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      line_ff      <= 12'h000;
      row_phase_ff <= 1'b0;
    end
    else if (frame_step)
    begin
      line_ff      <= 12'h000;
      row_phase_ff <= 1'b0;
    end
    else if (line_step)
    begin
      line_ff      <= line_ff + 12'h001;
      row_phase_ff <= ~row_phase_ff;
    end
  end

  wire pix_rst_now  = (line_ff < (len_eff - 12'h001)); // RL17
  wire dual_now     = seq.second_slope_enable & (line_ff == dual_pos_ff - 12'h001); // RL10
  wire triple_now   = seq.third_slope_enable & (line_ff == triple_pos_ff - 12'h001); // RL11
  wire ft_now       = (line_ff == ft_pos_ff - 12'h001); // RL18
  wire skip_now     = seq.row_subsample & row_phase_ff; // RL6
  wire calib_now    = seq.calib_every_line ? line_step : frame_step; // RL9

  // Master drives integration from registers; slave follows the pins
  wire [2:0] int_master = {triple_now, dual_now, ~pix_rst_now};
  wire [2:0] int_sel    = seq.master_mode ? int_master : int_sync_b_ff; // RL5
  wire       rst_sel    = seq.master_mode ? pix_rst_now : ~int_sync_b_ff[0]; // RL5
  wire       dual_sel   = seq.master_mode ? dual_now : int_sync_b_ff[1];
  wire       triple_sel = seq.master_mode ? triple_now : int_sync_b_ff[2];

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      CORE_TICK      <= 1'b0;
      SEQ_CTRL       <= iscr_seq_t'(RST_SEQ_CTRL);
      SHUTTER_DIV    <= 2'h0;
      START_PIXEL    <= 10'h000;
      START_ROW      <= 9'h000;
      KERNELS        <= 8'h00;
      ROW_SKIP       <= 1'b0;
      PIXEL_RESET    <= 1'b0;
      DUAL_RESET     <= 1'b0;
      TRIPLE_RESET   <= 1'b0;
      FRAME_TRANSFER <= 1'b0;
      INT_TIME_OUT   <= 3'h0;
      ANALOG_OUT_EN  <= 1'b0;
      CALIB_STROBE   <= 1'b0;
      CAL_REF        <= 8'h00;
      BLACK_REF      <= 8'h00;
      OFFSET_REF     <= 8'h00;
      INPUT_PATHS    <= '0;
      GAIN           <= '0;
      TRIM_WORD      <= 33'h000000000;
      WRITE_REFUSED  <= 1'b0;
    end
    else
    begin
      CORE_TICK      <= core_tick; // RL1
      SEQ_CTRL       <= seq; // RL12 RL13
      SHUTTER_DIV    <= seq.clock_granularity; // RL7
      START_PIXEL    <= {col_clamped[6:0], 3'h0}; // RL14
      START_ROW      <= row_clamped; // RL15
      KERNELS        <= ker_clamped; // RL16
      ROW_SKIP       <= skip_now; // RL6
      PIXEL_RESET    <= rst_sel;
      DUAL_RESET     <= dual_sel;
      TRIPLE_RESET   <= triple_sel;
      FRAME_TRANSFER <= ft_now;
      INT_TIME_OUT   <= int_sel;
      ANALOG_OUT_EN  <= seq.analog_out_enable; // RL8
      CALIB_STROBE   <= calib_now; // RL9
      CAL_REF        <= cal_ref_ff; // RL19
      BLACK_REF      <= black_ref_ff;
      OFFSET_REF     <= offset_ref_ff;
      INPUT_PATHS    <= iscr_paths_t'(paths_ff); // RL20
      GAIN           <= iscr_gain_t'(gain_ff); // RL21
      TRIM_WORD      <= {trim_high_ff, trim_mid_ff, trim_low_ff}; // RL22
      WRITE_REFUSED  <= refused_ff;
    end
  end

endmodule : iscr_config_regs

// ### design/iscr_pkg.sv
package iscr_pkg;

  localparam int          CORE_DIV          = 4;
  localparam logic [1:0]  CORE_DIV_LAST     = 2'h3;
  localparam int          WORD_BITS         = 16;
  localparam logic [4:0]  WORD_BITS_LAST    = 5'h0f;

  localparam logic [3:0]  ADDR_SEQ_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_START_COL    = 4'h1;
  localparam logic [3:0]  ADDR_START_ROW    = 4'h2;
  localparam logic [3:0]  ADDR_KERNELS      = 4'h3;
  localparam logic [3:0]  ADDR_RST_LEN      = 4'h4;
  localparam logic [3:0]  ADDR_DUAL_POS     = 4'h5;
  localparam logic [3:0]  ADDR_TRIPLE_POS   = 4'h6;
  localparam logic [3:0]  ADDR_FT_POS       = 4'h7;
  localparam logic [3:0]  ADDR_CAL_REF      = 4'h8;
  localparam logic [3:0]  ADDR_BLACK_REF    = 4'h9;
  localparam logic [3:0]  ADDR_OFFSET_REF   = 4'ha;
  localparam logic [3:0]  ADDR_INPUT_PATHS  = 4'hb;
  localparam logic [3:0]  ADDR_GAIN         = 4'hc;
  localparam logic [3:0]  ADDR_TRIM_LOW     = 4'hd;
  localparam logic [3:0]  ADDR_TRIM_MID     = 4'he;
  localparam logic [3:0]  ADDR_TRIM_HIGH    = 4'hf;

  localparam logic [10:0] RST_SEQ_CTRL      = 11'h029;
  localparam logic [7:0]  RST_START_COL     = 8'h00;
  localparam logic [8:0]  RST_START_ROW     = 9'h000;
  localparam logic [7:0]  RST_KERNELS       = 8'ha0;
  localparam logic [11:0] RST_RST_LEN       = 12'h002;
  localparam logic [11:0] RST_DUAL_POS      = 12'h000;
  localparam logic [11:0] RST_TRIPLE_POS    = 12'h000;
  localparam logic [11:0] RST_FT_POS        = 12'h1e1;
  localparam logic [7:0]  RST_CAL_REF       = 8'h4a;
  localparam logic [7:0]  RST_BLACK_REF     = 8'h6b;
  localparam logic [7:0]  RST_OFFSET_REF    = 8'h55;
  localparam logic [11:0] RST_INPUT_PATHS   = 12'h0f0;
  localparam logic [11:0] RST_GAIN          = 12'hfb0;
  localparam logic [11:0] RST_TRIM_LOW      = 12'hadf;
  localparam logic [11:0] RST_TRIM_MID      = 12'h6db;
  localparam logic [8:0]  RST_TRIM_HIGH     = 9'h0db;

  localparam logic [7:0]  START_COL_MAX     = 8'h4f;
  localparam logic [8:0]  START_ROW_MAX     = 9'h1df;
  localparam logic [7:0]  KERNELS_MAX       = 8'ha0;
  localparam logic [11:0] RST_LEN_MIN       = 12'h002;

  // Sequencer control fields, bit 10 downward
  typedef struct packed {
    logic       non_destructive;
    logic       reverse_y;
    logic       reverse_x;
    logic       third_slope_enable;
    logic       second_slope_enable;
    logic       calib_every_line;
    logic       analog_out_enable;
    logic [1:0] clock_granularity;
    logic       row_subsample;
    logic       master_mode;
  } iscr_seq_t;

  typedef struct packed {
    logic [3:0] bypass_mux;
    logic [3:0] normal_path;
    logic [3:0] test_path;
  } iscr_paths_t;

  typedef struct packed {
    logic       fast_calib;
    logic [3:0] converter_enable;
    logic       analog_in_enable;
    logic       half_gain_bypass;
    logic       unity_gain;
    logic [3:0] gain_code;
  } iscr_gain_t;

  typedef enum logic [1:0] {
    GRAN_BELOW_20,
    GRAN_20_TO_40,
    GRAN_40_TO_80,
    GRAN_ABOVE_80
  } iscr_gran_t;

endpackage : iscr_pkg

// ### design/iscr_core_clock_div.sv
`timescale 1ns/1ps
module iscr_core_clock_div
  import iscr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      core_tick
);

  logic [1:0] count_ff;
  logic [1:0] nxt_count;
  logic       tick_ff;

  assign nxt_count = count_ff + 2'h1;
  assign core_tick = tick_ff;

  // One tick every fourth input clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_ff <= 2'h0;
      tick_ff  <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      tick_ff  <= (count_ff == CORE_DIV_LAST);
    end
  end

endmodule : iscr_core_clock_div

// ### test/iscr_config_regs_assertions.sv
`timescale 1ns/1ps
module iscr_config_regs_checker
  import iscr_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  input wire logic       FRAME_VALID,
  input wire logic       CORE_TICK,
  input wire iscr_seq_t  SEQ_CTRL,
  input wire logic [1:0] SHUTTER_DIV,
  input wire logic [9:0] START_PIXEL,
  input wire logic [7:0] KERNELS,
  input wire logic       DUAL_RESET,
  input wire logic       ANALOG_OUT_EN,
  input wire logic       CALIB_STROBE,
  input wire logic [7:0] CAL_REF,
  input wire iscr_gain_t GAIN
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  AST_TICK_PERIOD: assert property (CORE_TICK |=> !CORE_TICK [*3] ##1 CORE_TICK)
    else $error("core tick spacing wrong");
  AST_CTRL_RESET: assert property (disable iff (1'b0) !RST_N ##1 !RST_N |-> SEQ_CTRL == RST_SEQ_CTRL)
    else $error("control register not at default in reset");
  AST_MODE_LOCKED: assert property ($past(RST_N) |->
    $stable({SEQ_CTRL.clock_granularity, SEQ_CTRL.master_mode}))
    else $error("mode or granularity changed outside reset");
  AST_GRAN_OUT: assert property ($past(RST_N) |-> SHUTTER_DIV == SEQ_CTRL.clock_granularity)
    else $error("shutter division differs from granularity");
  AST_COL_GROUPS: assert property (START_PIXEL[2:0] == 3'h0 && START_PIXEL <= {START_COL_MAX, 3'h0})
    else $error("start pixel not a legal group start");
  AST_KERNEL_RANGE: assert property ($past(RST_N) |-> KERNELS != 8'h00 && KERNELS <= KERNELS_MAX)
    else $error("kernel count out of range");
  AST_ANALOG_OUT: assert property ($rose(SEQ_CTRL.analog_out_enable) |-> ##[0:2] ANALOG_OUT_EN)
    else $error("analog output not enabled");
  AST_DUAL_OFF: assert property (!SEQ_CTRL.second_slope_enable && !$past(SEQ_CTRL.second_slope_enable) |-> !DUAL_RESET)
    else $error("dual reset while disabled");
  AST_REFUSED_HOLD: assert property (FRAME_VALID [*8] |-> $stable(CAL_REF) && $stable(GAIN))
    else $error("register changed during frame");
  AST_STROBE_PULSE: assert property (CALIB_STROBE |=> !CALIB_STROBE)
    else $error("calibration strobe too long");
endmodule : iscr_config_regs_checker

bind iscr_config_regs iscr_config_regs_checker i_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .FRAME_VALID(FRAME_VALID), .CORE_TICK(CORE_TICK),
  .SEQ_CTRL(SEQ_CTRL), .SHUTTER_DIV(SHUTTER_DIV), .START_PIXEL(START_PIXEL),
  .KERNELS(KERNELS), .DUAL_RESET(DUAL_RESET), .ANALOG_OUT_EN(ANALOG_OUT_EN),
  .CALIB_STROBE(CALIB_STROBE), .CAL_REF(CAL_REF), .GAIN(GAIN)
);

// ### test/iscr_ctrl_model.sv
`timescale 1ns/1ps
module iscr_ctrl_model
  import iscr_pkg::*;
(
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_enable,
  output logic      ser_data
);
  initial
  begin
    ser_clk = 1'b0;
    ser_enable = 1'b0;
    ser_data = 1'b0;
  end

  // Levels span four cycles so the synchroniser never misses one
  task automatic send(input logic [3:0] addr, input logic [11:0] data);
    logic [15:0] word;
    begin
      word = {addr, data};
      for (int i = 15; i >= 0; i--)
      begin
        @(negedge clk);
        ser_data = word[i];
        repeat (4) @(negedge clk);
        ser_clk = 1'b1;
        repeat (4) @(negedge clk);
        ser_clk = 1'b0;
      end
      // Released line shows the inverse, not the last bit
      ser_data = ~word[0];
      repeat (4) @(negedge clk);
      ser_enable = 1'b1;
      repeat (4) @(negedge clk);
      ser_enable = 1'b0;
      repeat (8) @(negedge clk);
    end
  endtask : send
endmodule : iscr_ctrl_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench
  import iscr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fv = 1'b0;
  logic        line_done = 1'b0;
  logic        frame_start = 1'b0;
  logic        sclk, sen, sdat, tick, skip, pix_rst, dual_rst, tri_rst, ft, aout, stb, refused;
  iscr_seq_t   seq;
  iscr_paths_t paths;
  iscr_gain_t  gain;
  logic [1:0]  shut_div;
  logic [9:0]  start_pix;
  logic [8:0]  start_row;
  logic [7:0]  kernels, cal_ref, black_ref, off_ref;
  logic [2:0]  int_out;
  logic [32:0] trim;
  int          failures = 0;
  int          cmp_count = 0;
  int          n;
  int          stb_seen = 0;

  iscr_config_regs i_dut (
    .REF_CLK(clk), .RST_N(rst_n), .SER_CLK(sclk), .SER_ENABLE(sen), .SER_DATA(sdat),
    .FRAME_VALID(fv), .INT_TIME_IN(3'h0), .LINE_DONE(line_done), .FRAME_START(frame_start),
    .CORE_TICK(tick), .SEQ_CTRL(seq), .SHUTTER_DIV(shut_div), .START_PIXEL(start_pix),
    .START_ROW(start_row), .KERNELS(kernels), .ROW_SKIP(skip), .PIXEL_RESET(pix_rst),
    .DUAL_RESET(dual_rst), .TRIPLE_RESET(tri_rst), .FRAME_TRANSFER(ft), .INT_TIME_OUT(int_out),
    .ANALOG_OUT_EN(aout), .CALIB_STROBE(stb), .CAL_REF(cal_ref), .BLACK_REF(black_ref),
    .OFFSET_REF(off_ref), .INPUT_PATHS(paths), .GAIN(gain), .TRIM_WORD(trim),
    .WRITE_REFUSED(refused)
  );
  iscr_ctrl_model i_ctl (.clk(clk), .ser_clk(sclk), .ser_enable(sen), .ser_data(sdat));

  always #50 clk = ~clk;

  // Strobe is one cycle wide, so each pulse is seen at exactly one falling edge
  always @(negedge clk) stb_seen += stb;

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One tick-wide level is counted exactly once
  task automatic step(input logic fs);
    @(negedge clk);
    frame_start = fs;
    line_done = ~fs;
    repeat (4) @(negedge clk);
    frame_start = 1'b0;
    line_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask : step

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    #2000000;
    failures++;
    test_done();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("seq", seq, RST_SEQ_CTRL);
    chk("kernels", kernels, RST_KERNELS);
    chk("gain", gain, RST_GAIN);
    chk("trim", trim, {RST_TRIM_HIGH, RST_TRIM_MID, RST_TRIM_LOW});
    chk("offset", off_ref, RST_OFFSET_REF);
    chk("black", black_ref, RST_BLACK_REF);
    chk("paths", paths, RST_INPUT_PATHS);
    chk("div", shut_div, GRAN_40_TO_80);
    chk("aout", aout, 1'b0);
    n = 0;
    repeat (40)
    begin
      @(negedge clk);
      n += tick;
    end
    chk("ticks", n, 10);
    $display("defaults done");
    i_ctl.send(ADDR_START_COL, 12'h017);
    chk("col", start_pix, 10'h0b8);
    i_ctl.send(ADDR_START_COL, 12'h050);
    chk("col max", start_pix, 10'h278);
    i_ctl.send(ADDR_START_ROW, 12'hfdf);
    chk("row", start_row, 9'h1df);
    i_ctl.send(ADDR_KERNELS, 12'h000);
    chk("kern min", kernels, 8'h01);
    i_ctl.send(ADDR_KERNELS, 12'hf25);
    chk("kern", kernels, 8'h25);
    i_ctl.send(ADDR_CAL_REF, 12'hf12);
    chk("cal", cal_ref, 8'h12);
    i_ctl.send(ADDR_INPUT_PATHS, 12'h321);
    chk("paths w", paths.bypass_mux, 4'h3);
    i_ctl.send(ADDR_GAIN, 12'h5a7);
    chk("gain w", gain, 12'h5a7);
    i_ctl.send(ADDR_TRIM_LOW, 12'h123);
    i_ctl.send(ADDR_TRIM_MID, 12'h456);
    i_ctl.send(ADDR_TRIM_HIGH, 12'hf89);
    chk("trim w", trim, {9'h189, 12'h456, 12'h123});
    i_ctl.send(ADDR_SEQ_CTRL, 12'h7f6);
    chk("seq w", seq, 11'h7fb);
    chk("aout w", aout, 1'b1);
    chk("div w", shut_div, 2'h2);
    $display("writes done");
    fv = 1'b1;
    i_ctl.send(ADDR_CAL_REF, 12'h099);
    chk("cal held", cal_ref, 8'h12);
    chk("refused", refused, 1'b1);
    fv = 1'b0;
    i_ctl.send(ADDR_CAL_REF, 12'h099);
    chk("cal late", cal_ref, 8'h99);
    chk("accepted", refused, 1'b0);
    $display("refusal done");
    i_ctl.send(ADDR_FT_POS, 12'h003);
    i_ctl.send(ADDR_DUAL_POS, 12'h003);
    n = stb_seen;
    step(1'b1);
    chk("reset l0", pix_rst, 1'b1);
    step(1'b0);
    chk("reset l1", pix_rst, 1'b0);
    chk("ft l1", ft, 1'b0);
    chk("skip l1", skip, 1'b1);
    step(1'b0);
    chk("ft l2", ft, 1'b1);
    chk("dual l2", dual_rst, 1'b1);
    chk("tri l2", tri_rst, 1'b0);
    chk("skip l2", skip, 1'b0);
    chk("int l2", int_out, 3'h3);
    chk("strobes", stb_seen - n, 2);
    $display("lines done");
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("seq rst", seq, RST_SEQ_CTRL);
    chk("cal rst", cal_ref, RST_CAL_REF);
    chk("col rst", start_pix, 10'h000);
    $display("second reset done");
    test_done();
  end
endmodule : testbench
